// ==== hw/dacr_pkg.sv ====
// Constants and carrier types for the dual converter readout block
package dacr_pkg;

  // Clock rate and conversion timing
  localparam int unsigned MCLK_HZ            = 20_000_000;
  localparam int unsigned CONV_NS_14         = 680;
  localparam int unsigned CONV_NS_12         = 610;
  localparam int unsigned CONV_CYC_14        = (CONV_NS_14 * (MCLK_HZ / 1_000_000)) / 1000;
  localparam int unsigned CONV_CYC_12        = (CONV_NS_12 * (MCLK_HZ / 1_000_000)) / 1000;
  // Busy is raised at most this long after the start edge; the sequencer raises it 100 to 150 ns after start falls
  localparam int unsigned BUSY_RISE_NS       = 40;
  // Shutdown wake time and its cycle count
  localparam int unsigned WAKE_US            = 70;
  localparam int unsigned WAKE_CYC           = WAKE_US * (MCLK_HZ / 1_000_000);

  // Result widths and slot length on one output
  localparam int unsigned BITS_14            = 14;
  localparam int unsigned BITS_12            = 12;
  localparam int unsigned SLOT_BITS          = 14;
  localparam int unsigned FRAME_BITS         = 2 * SLOT_BITS;

  localparam logic [4:0]  CNT_W5_ZERO        = 5'h00;
  localparam logic [13:0] RESULT_RST         = 14'h0000;

  // Pair of conversion results carried across the clock boundary
  typedef struct packed {
    logic [13:0] first;
    logic [13:0] second;
  } dacr_result_s;

  // Serial pin group toward the controller
  typedef struct packed {
    logic data_first;
    logic data_second;
    logic oe;
  } dacr_pins_s;

  // Conversion state machine
  typedef enum logic [2:0] {
    DACR_IDLE = 3'b001,
    DACR_CONV = 3'b010,
    DACR_DONE = 3'b100
  } dacr_state_e;

endpackage : dacr_pkg

// ==== hw/dacr_shifter.sv ====
// Serial shifter on the read clock: loads results, shifts on falling edge
`timescale 1ns/1ps
`default_nettype none
module dacr_shifter
  import dacr_pkg::*;
(
  input  wire logic         sclk,
  input  wire logic         arst_n,
  input  wire logic         cs_n,
  input  wire logic         is_12bit,
  input  wire logic         load_tgl,
  input  wire dacr_result_s result,
  output var  logic         out_first,
  output var  logic         out_second
);

  logic [27:0] sh_first_reg;
  logic [27:0] sh_second_reg;
  logic [27:0] sh_first_next;
  logic [27:0] sh_second_next;
  logic        tgl_s1_reg;
  logic        tgl_s2_reg;
  logic        tgl_seen_reg;

  // Left-align one slot: 12-bit results are followed by two zeros
  function automatic logic [13:0] slot(input logic [13:0] v, input logic s12);
    slot = s12 ? {v[11:0], 2'h0} : v;
  endfunction : slot

  ////////////////////////////////////////////////////////////////////////////
  // Next shift contents: reload on a new result, else shift while selected
  always_comb begin
    sh_first_next  = sh_first_reg;
    sh_second_next = sh_second_reg;
    if (tgl_s2_reg != tgl_seen_reg) begin
      // Own result first, the other one follows in the next slot [R11] [R12]
      sh_first_next  = {slot(result.first, is_12bit),
                        slot(result.second, is_12bit)};
      sh_second_next = {slot(result.second, is_12bit),
                        slot(result.first, is_12bit)};
    end else if (!cs_n) begin
      sh_first_next  = {sh_first_reg[26:0], 1'b0};            // [R8] [R10]
      sh_second_next = {sh_second_reg[26:0], 1'b0};
    end
  end

  // Registers on the falling read-clock edge, so data moves after it
  always_ff @(negedge sclk or negedge arst_n) begin
    if (!arst_n) begin
      sh_first_reg  <= 28'h0000000;
      sh_second_reg <= 28'h0000000;
      tgl_s1_reg    <= 1'b0;
      tgl_s2_reg    <= 1'b0;
      tgl_seen_reg  <= 1'b0;
    end else begin
      sh_first_reg  <= sh_first_next;
      sh_second_reg <= sh_second_next;
      tgl_s1_reg    <= load_tgl;
      tgl_s2_reg    <= tgl_s1_reg;
      tgl_seen_reg  <= tgl_s2_reg;
    end
  end

  // MSB of the shift register drives each pin
  assign out_first  = sh_first_reg[27];
  assign out_second = sh_second_reg[27];

endmodule : dacr_shifter
`default_nettype wire

// ==== hw/dacr_top.sv ====
// Conversion control and serial readout of a dual sampling converter
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// R1: Busy falls within 680 ns (14-bit) or 610 ns (12-bit) of start.
// R2: Controller holds conversion start low at least 10 ns.
// R3: Read clock between 10 kHz and 35 or 48 MHz.
// R4: Controller leaves 30 ns between read end and next conversion.
// R5: Controller waits up to 70 us start high-to-low when waking.
// R6: With select low, MSB appears no earlier than busy falling.
// R7: Outputs enable when select falls, float when select rises.
// R8: Data outputs change after each falling edge of the read clock.
// R9: Read clock low and high phases each at least 0.3 period.
// R10: Each output gives its own result MSB first, 12 or 14 bits.
// R11: Fourteen more clocks with select low deliver the other result.
// R12: On the 12-bit variant the second result follows two zeros.
// R13: Controller reads after busy falls, never starts while busy.
module dacr_top
  import dacr_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        arst_n,
  input  wire logic        conversion_start_n,
  input  wire logic        cs_n,
  input  wire logic        sclk,
  input  wire logic        is_12bit,
  input  wire logic        shutdown,
  input  wire logic [13:0] sample_first,
  input  wire logic [13:0] sample_second,
  output var  logic        busy,
  output var  logic        serial_out_first,
  output var  logic        serial_out_second,
  output var  logic        serial_oe_first,
  output var  logic        serial_oe_second
);

  dacr_state_e  state_reg;
  dacr_state_e  state_next;
  logic [11:0]  cnt_reg;
  logic [11:0]  cnt_next;
  logic [11:0]  wake_reg;
  logic [11:0]  wake_next;
  logic         cnv_s1_reg;
  logic         cnv_s2_reg;
  logic         cnv_d_reg;
  logic         shd_s1_reg;
  logic         shd_s2_reg;
  logic         s12_s1_reg;
  logic         busy_reg;
  logic         busy_next;
  logic         tgl_reg;
  logic         tgl_next;
  logic         s12_reg;
  dacr_result_s res_reg;
  dacr_result_s res_next;
  logic         sh_first;
  logic         sh_second;
  logic         start_fall;

  // Conversion length in cycles for the selected variant
  function automatic logic [11:0] conv_len(input logic s12);
    conv_len = s12 ? 12'(CONV_CYC_12) : 12'(CONV_CYC_14);
  endfunction : conv_len

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers (start, shutdown, variant) and start falling-edge detect
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      cnv_s1_reg <= 1'b1;
      cnv_s2_reg <= 1'b1;
      cnv_d_reg  <= 1'b1;
      shd_s1_reg <= 1'b0;
      shd_s2_reg <= 1'b0;
      s12_s1_reg <= 1'b0;
      s12_reg    <= 1'b0;
    end else begin
      cnv_s1_reg <= conversion_start_n;
      cnv_s2_reg <= cnv_s1_reg;
      cnv_d_reg  <= cnv_s2_reg;
      shd_s1_reg <= shutdown;
      shd_s2_reg <= shd_s1_reg;
      s12_s1_reg <= is_12bit;
      s12_reg    <= s12_s1_reg;
    end
  end

  assign start_fall = cnv_d_reg & ~cnv_s2_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Conversion sequencer: busy high for the conversion time less the three-cycle start sync
  always_comb begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    busy_next  = busy_reg;
    tgl_next   = tgl_reg;
    res_next   = res_reg;
    wake_next  = wake_reg;
    // Wake counter restarts in shutdown; conversions wait for it
    if (shd_s2_reg) begin
      wake_next = 12'(WAKE_CYC);
    end else if (wake_reg != 12'h000 && cnv_s2_reg) begin
      wake_next = wake_reg - 12'h001;
    end
    unique case (state_reg)
      DACR_IDLE: begin
        if (start_fall && !shd_s2_reg && wake_reg == 12'h000) begin
          state_next = DACR_CONV;
          busy_next  = 1'b1;
          // Sync latency counted against the conversion time [R1]
          cnt_next   = conv_len(s12_reg) - 12'h004;
          res_next.first  = sample_first;
          res_next.second = sample_second;
        end
      end
      DACR_CONV: begin
        if (cnt_reg == 12'h000) begin
          state_next = DACR_DONE;
          busy_next  = 1'b0;                                   // [R1]
          tgl_next   = ~tgl_reg;                               // [R6]
        end else begin
          cnt_next = cnt_reg - 12'h001;
        end
      end
      DACR_DONE: begin
        state_next = DACR_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= DACR_IDLE;
      cnt_reg   <= 12'h000;
      wake_reg  <= 12'h000;
      busy_reg  <= 1'b0;
      tgl_reg   <= 1'b0;
      res_reg   <= '{first: RESULT_RST, second: RESULT_RST};
    end else begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
      wake_reg  <= wake_next;
      busy_reg  <= busy_next;
      tgl_reg   <= tgl_next;
      res_reg   <= res_next;
    end
  end

  assign busy = busy_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Read-clock side shifter; result is stable while the toggle crosses
  dacr_shifter u_shifter (
    .sclk       (sclk),
    .arst_n     (arst_n),
    .cs_n       (cs_n),
    .is_12bit   (is_12bit),
    .load_tgl   (tgl_reg),
    .result     (res_reg),
    .out_first  (sh_first),
    .out_second (sh_second)
  );

  // Output enables follow chip select directly at the pin [R7]
  assign serial_oe_first   = ~cs_n;
  assign serial_oe_second  = ~cs_n;
  assign serial_out_first  = sh_first;
  assign serial_out_second = sh_second;

endmodule : dacr_top
`default_nettype wire

// ==== bench/dacr_properties.sv ====
// Port checks of the dual converter readout block
`timescale 1ns/1ps
`default_nettype none
module dacr_properties
  import dacr_pkg::*;
(
  input wire logic        mclk,
  input wire logic        arst_n,
  input wire logic        conversion_start_n,
  input wire logic        cs_n,
  input wire logic        sclk,
  input wire logic        is_12bit,
  input wire logic        shutdown,
  input wire logic [13:0] sample_first,
  input wire logic [13:0] sample_second,
  input wire logic        busy,
  input wire logic        serial_out_first,
  input wire logic        serial_out_second,
  input wire logic        serial_oe_first,
  input wire logic        serial_oe_second
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!arst_n);
  // Start while idle (busy low) and shutdown low, wake time not checked, and its end
  sequence s_start;
    $fell(conversion_start_n) && !busy && !shutdown;
  endsequence
  sequence s_end;
    $fell(busy);
  endsequence
  ////////////////////////////////////////////////////////////////////////////
  // Timing and output checks
  a_conv_time_wide: assert property (
    s_start ##0 !is_12bit |-> ##[1:13] s_end) else $error("wide slow");
  a_conv_time_narrow: assert property (
    s_start ##0 is_12bit |-> ##[1:12] s_end) else $error("narrow slow");
  a_no_wake_start: assert property (
    $past(shutdown, 2) |-> !$rose(busy)) else $error("started in shutdown");
  a_oe_first: assert property (
    serial_oe_first == !cs_n) else $error("first enable wrong");
  a_oe_second: assert property (
    serial_oe_second == !cs_n) else $error("second enable wrong");
  a_hold_while_busy: assert property (
    busy && $past(busy) |-> $stable(serial_out_first)
    && $stable(serial_out_second)) else $error("data moved in busy");
  a_shift_on_fall: assert property (
    sclk && $past(sclk) |-> $stable(serial_out_first)
    && $stable(serial_out_second)) else $error("data moved clk high");
endmodule : dacr_properties
bind dacr_top dacr_properties dacr_properties_inst (.mclk(mclk),
  .arst_n(arst_n), .conversion_start_n(conversion_start_n), .cs_n(cs_n),
  .sclk(sclk), .is_12bit(is_12bit), .shutdown(shutdown),
  .sample_first(sample_first), .sample_second(sample_second),
  .busy(busy), .serial_out_first(serial_out_first),
  .serial_out_second(serial_out_second),
  .serial_oe_first(serial_oe_first), .serial_oe_second(serial_oe_second));
`default_nettype wire

// ==== bench/dacr_host_model.sv ====
// Controller model: framed read clock and bit capture
`timescale 1ns/1ps
`default_nettype none
module dacr_host_model (
  output var  logic sclk,
  output var  logic cs_n,
  input  wire logic pin_first,
  input  wire logic pin_second
);
  // Clock idles high, select idles high
  initial begin
    sclk = 1'b1;
    cs_n = 1'b1;
  end
  // Three loading falls, then one bit per clock, taken while clock is high
  task automatic read_frame(output logic [27:0] ga, output logic [27:0] gb);
    cs_n = 1'b0;
    #20;
    repeat (3) begin
      sclk = 1'b0; // 8 MHz, even phases
      #62.5;
      sclk = 1'b1;
      #62.5;
    end
    for (int i = 27; i >= 0; i--) begin
      ga[i] = pin_first;
      gb[i] = pin_second;
      sclk = 1'b0;
      #62.5;
      sclk = 1'b1;
      #62.5;
    end
    cs_n = 1'b1;
  endtask : read_frame
endmodule : dacr_host_model
`default_nettype wire

// ==== bench/tb_top.sv ====
// Self-checking bench of the dual converter readout block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import dacr_pkg::*;
  logic        mclk = 1'b0;
  logic        arst_n = 1'b0;
  logic        conversion_start_n = 1'b1;
  logic        is_12bit = 1'b0;
  logic        shutdown = 1'b0;
  logic [13:0] smp_a = 14'h2C5B;
  logic [13:0] smp_b = 14'h13A4;
  wire logic   sclk, cs_n, busy, out_a, out_b, oe_a, oe_b;
  int          mismatches = 0;
  int          checks_done = 0;
  int          n;
  int          done_ns;
  always #25 mclk = ~mclk;
  dacr_top dacr_top_inst (.mclk(mclk), .arst_n(arst_n),
    .conversion_start_n(conversion_start_n), .cs_n(cs_n), .sclk(sclk),
    .is_12bit(is_12bit), .shutdown(shutdown), .sample_first(smp_a),
    .sample_second(smp_b), .busy(busy), .serial_out_first(out_a),
    .serial_out_second(out_b), .serial_oe_first(oe_a),
    .serial_oe_second(oe_b));
  dacr_host_model dacr_host_model_inst (.sclk(sclk), .cs_n(cs_n),
    .pin_first(oe_a ? out_a : ~out_a), .pin_second(oe_b ? out_b : ~out_b));
  ////////////////////////////////////////////////////////////////////////////
  // Compare and count
  task automatic check(input logic [27:0] seen, input logic [27:0] want);
    checks_done++;
    if (seen !== want) begin
      mismatches++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, want);
    end
  endtask : check
  // Start pulse of two cycles, then count cycles with busy high
  task automatic convert();
    n = 0;
    done_ns = 0;
    conversion_start_n <= 1'b0;
    repeat (2) @(posedge mclk);
    conversion_start_n <= 1'b1;
    // Busy read between edges; note how long after the start edge it fell
    for (int i = 3; i <= 22; i++) begin
      @(negedge mclk);
      if (busy === 1'b1) n++;
      else if (n > 0 && done_ns == 0) done_ns = (i - 1) * 50;
    end
    @(posedge mclk);
  endtask : convert
  // One framed read after busy, both outputs compared
  task automatic read_check(input logic [27:0] wa, wb, mask);
    logic [27:0] ga, gb;
    dacr_host_model_inst.read_frame(ga, gb);
    check(ga & mask, wa);
    check(gb & mask, wb);
    repeat (2) @(posedge mclk);
    check({27'h0, oe_a | oe_b}, 28'h0);
  endtask : read_check
  ////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic scn_wide();
    convert();
    check(28'(n >= 1 && n <= CONV_CYC_14 - 3), 28'h1);
    check(28'(done_ns > 0 && done_ns <= CONV_NS_14), 28'h1);
    read_check({smp_a, smp_b}, {smp_b, smp_a}, 28'hFFFFFFF);
  endtask : scn_wide
  task automatic scn_sleep();
    shutdown <= 1'b1;
    @(posedge mclk);
    convert();
    check(28'(n), 28'h0);
    shutdown <= 1'b0;
    repeat (WAKE_CYC + 10) @(posedge mclk);
    convert();
    check(28'(n > 0), 28'h1);
    read_check({smp_a, smp_b}, {smp_b, smp_a}, 28'hFFFFFFF);
  endtask : scn_sleep
  task automatic scn_narrow();
    is_12bit <= 1'b1;
    smp_a <= 14'h1555;
    smp_b <= 14'h2AAA;
    @(posedge mclk);
    convert();
    check(28'(n >= 1 && n <= CONV_CYC_12 - 3), 28'h1);
    check(28'(done_ns > 0 && done_ns <= CONV_NS_12), 28'h1);
    read_check({12'h555, 2'b00, 12'hAAA, 2'b00},
      {12'hAAA, 2'b00, 12'h555, 2'b00}, 28'hFFFFFFC);
  endtask : scn_narrow
  ////////////////////////////////////////////////////////////////////////////
  // Verdict and end of run
  task automatic report_and_stop();
    if (mismatches == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : report_and_stop
  // Main sequence
  initial begin
    repeat (6) @(posedge mclk);
    arst_n <= 1'b1;
    @(posedge mclk);
    scn_wide();
    scn_sleep();
    scn_narrow();
    report_and_stop();
  end
  // Watchdog
  initial begin
    #1_000_000;
    mismatches++;
    report_and_stop();
  end
endmodule : tb_top
`default_nettype wire
